// >>> include/mte_pkg.sv
`default_nettype none
package mte_pkg;

  localparam int unsigned XW = 32;

  // ==========================================================
  // register offsets (byte addresses on the register bus)
  localparam logic [7:0] OFS_PEH  = 8'h00;
  localparam logic [7:0] OFS_PEL  = 8'h04;
  localparam logic [7:0] OFS_PEA  = 8'h08;
  localparam logic [7:0] OFS_FAR  = 8'h0c;
  localparam logic [7:0] OFS_CODE = 8'h10;
  localparam logic [7:0] OFS_SPC  = 8'h14;
  localparam logic [7:0] OFS_SST  = 8'h18;
  localparam logic [7:0] OFS_SGR  = 8'h1c;
  localparam logic [7:0] OFS_VBR  = 8'h20;
  localparam logic [7:0] OFS_XCTL = 8'h24;
  localparam logic [7:0] OFS_STW  = 8'h28;

  // ==========================================================
  // field layout
  localparam int unsigned PAGE_LSB = 10;
  localparam int unsigned MD_POS   = 30;
  localparam int unsigned RB_POS   = 29;
  localparam int unsigned BL_POS   = 28;
  localparam int unsigned CNT_LSB  = 0;
  localparam int unsigned BND_LSB  = 8;
  localparam int unsigned CNT_W    = 6;

  // ==========================================================
  // event codes and vectors
  localparam logic [11:0] CODE_NONE    = 12'h000;
  localparam logic [11:0] CODE_MISS_RD = 12'h040;
  localparam logic [11:0] CODE_MISS_WR = 12'h060;
  localparam logic [11:0] CODE_IPW     = 12'h080;
  localparam logic [11:0] CODE_PROT_RD = 12'h0a0;
  localparam logic [11:0] CODE_PROT_WR = 12'h0c0;
  localparam logic [11:0] CODE_MULTI   = 12'h140;
  localparam logic [31:0] VEC_RESET    = 32'ha000_0000;
  localparam logic [31:0] OFS_GENERAL  = 32'h0000_0100;
  localparam logic [31:0] OFS_MISS     = 32'h0000_0400;

  // ==========================================================
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_STW  = 32'h7000_00f0;

  // one memory access presented by the pipeline
  typedef struct packed {
    logic          is_data;
    logic          is_write;
    logic          delay_slot;
    logic [XW-1:0] vaddr;
    logic [XW-1:0] pc;
    logic [XW-1:0] branch_pc;
  } mte_acc_t;

  // lookup result from the translation buffer searched
  typedef struct packed {
    logic multi;
    logic miss;
    logic prot_ok;
    logic written;
  } mte_look_t;

  typedef enum logic [2:0] {
    EK_NONE, EK_RESET, EK_MISS, EK_PROT, EK_IPW
  } mte_kind_t;

endpackage
`default_nettype wire

// >>> hdl/mte_unit.sv
// Function
// RQ1: fetch hitting valid entry with forbidden key raises protection fault.
// RQ2: instruction protection fault loads event code 0A0.
// RQ3: two or more unified entries matching a data access raise multiple hit.
// RQ4: multiple match in refill lookup also raises data multiple hit.
// RQ5: multiple hit stores address, code 140, branches to reset handler.
// RQ6: multiple hit acts as reset; coherency, page numbers not guaranteed.
// RQ7: no unified entry for a data access raises data miss.
// RQ8: miss code 040 read, 060 write; cache ops classed read or write.
// RQ9: data miss vectors to vector base plus 400.
// RQ10: data hit with forbidden key raises data protection fault.
// RQ11: data protection code 0A0 read, 0C0 write.
// RQ12: protection and initial write faults vector to vector base plus 100.
// RQ13: permitted write to entry with written flag 0 raises initial write.
// RQ14: initial page write loads event code 080.
// RQ15: non-reset faults store page number and full fault address.
// RQ16: saved counter holds faulting pc, or delayed branch pc in slot.
// RQ17: status word and stack register saved on non-reset faults.
// RQ18: non-reset faults set privilege, block and bank bits to 1.
// RQ19: handler software loads low/assist registers then issues buffer load.
// RQ20: software fixes replace counter above bound after buffer load.
// RQ21: software keeps one instruction between buffer load and return.
// RQ22: initial write handler sets written flag in memory before reload.
// RQ23: buffer load copies entry registers to unified entry at counter.
// RQ24: instruction multiple hit stores address, code 140, reset handler.
// RQ25: one report per access: multi, then miss, protection, initial write.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`default_nettype none
module mte_unit
  import mte_pkg::*;
#(
  parameter int unsigned ENTRIES = 64
)(
  input  wire logic             CLK_I,
  input  wire logic             RST_I,
  input  wire logic             PSEL_I,
  input  wire logic             PENABLE_I,
  input  wire logic             PWRITE_I,
  input  wire logic [7:0]       PADDR_I,
  input  wire logic [31:0]      PWDATA_I,
  output logic      [31:0]      PRDATA_O,
  output logic                  PREADY_O,
  output logic                  PSLVERR_O,
  input  wire logic             ACC_VALID_I,
  input  wire mte_acc_t         ACC_I,
  input  wire mte_look_t        LOOK_I,
  input  wire logic             REFILL_MULTI_I,
  input  wire logic [31:0]      STACK_I,
  input  wire logic             LOAD_I,
  output logic                  EXC_O,
  output logic                  EXC_RESET_O,
  output logic      [31:0]      VECTOR_O,
  output logic      [31:0]      STATUS_O,
  output logic                  UB_WE_O,
  output logic      [CNT_W-1:0] UB_IDX_O,
  output logic      [31:0]      UB_HI_O,
  output logic      [31:0]      UB_LO_O,
  output logic      [31:0]      UB_AS_O
);

  // ==========================================================
  // registers
  logic [31:0]      page_entry_high_ff;
  logic [31:0]      page_entry_low_ff;
  logic [31:0]      page_entry_assist_ff;
  logic [31:0]      fault_address_reg_ff;
  logic [11:0]      exception_event_code_ff;
  logic [31:0]      saved_program_counter_ff;
  logic [31:0]      saved_status_ff;
  logic [31:0]      saved_general_ff;
  logic [31:0]      vector_base_ff;
  logic [31:0]      status_word_ff;
  logic [CNT_W-1:0] replace_counter_ff;
  logic [CNT_W-1:0] replace_bound_ff;
  logic [31:0]      prdata_ff;
  logic             exc_ff;
  logic             exc_reset_ff;
  logic [31:0]      vector_ff;
  logic             ub_we_ff;
  logic [CNT_W-1:0] ub_idx_ff;
  logic [31:0]      ub_hi_ff;
  logic [31:0]      ub_lo_ff;
  logic [31:0]      ub_as_ff;

  // ==========================================================
  // bus decode
  logic        wr_en;
  logic        rd_setup;
  logic        addr_hit;
  logic [31:0] rd_mux;

  assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I & addr_hit;
  assign rd_setup = PSEL_I & ~PENABLE_I;

  always_comb
  begin
    addr_hit = 1'b1;
    rd_mux   = RST_ZERO;
    unique case (PADDR_I)
      OFS_PEH:  rd_mux = page_entry_high_ff;
      OFS_PEL:  rd_mux = page_entry_low_ff;
      OFS_PEA:  rd_mux = page_entry_assist_ff;
      OFS_FAR:  rd_mux = fault_address_reg_ff;
      OFS_CODE: rd_mux = {20'h0_0000, exception_event_code_ff};
      OFS_SPC:  rd_mux = saved_program_counter_ff;
      OFS_SST:  rd_mux = saved_status_ff;
      OFS_SGR:  rd_mux = saved_general_ff;
      OFS_VBR:  rd_mux = vector_base_ff;
      OFS_STW:  rd_mux = status_word_ff;
      OFS_XCTL:
      begin
        rd_mux[CNT_LSB +: CNT_W] = replace_counter_ff;
        rd_mux[BND_LSB +: CNT_W] = replace_bound_ff;
      end
      default:  addr_hit = 1'b0;
    endcase
  end

  // zero wait states: read data sampled in the setup cycle
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_hit;
  assign PRDATA_O  = prdata_ff;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      prdata_ff <= RST_ZERO;
    else if (rd_setup)
      prdata_ff <= rd_mux;
  end

  // ==========================================================
  // exception detection and selection
  mte_kind_t   kind;
  logic [11:0] nxt_code;
  logic [31:0] nxt_vector;
  logic        blocked;
  logic        take;
  logic        take_gen;

  always_comb
  begin
    kind     = EK_NONE;
    nxt_code = CODE_NONE;
    if (ACC_VALID_I && ACC_I.is_data)
    begin
      if (LOOK_I.multi)
      begin
        kind     = EK_RESET; // RQ3 RQ25
        nxt_code = CODE_MULTI; // RQ5
      end
      else if (LOOK_I.miss)
      begin
        kind     = EK_MISS; // RQ7
        nxt_code = ACC_I.is_write ? CODE_MISS_WR : CODE_MISS_RD; // RQ8
      end
      else if (!LOOK_I.prot_ok)
      begin
        kind     = EK_PROT; // RQ10
        nxt_code = ACC_I.is_write ? CODE_PROT_WR : CODE_PROT_RD; // RQ11
      end
      else if (ACC_I.is_write && !LOOK_I.written)
      begin
        kind     = EK_IPW; // RQ13
        nxt_code = CODE_IPW; // RQ14
      end
    end
    else if (ACC_VALID_I)
    begin
      if (LOOK_I.multi || REFILL_MULTI_I)
      begin
        kind     = EK_RESET; // RQ4 RQ24
        nxt_code = CODE_MULTI; // RQ24
      end
      else if (!LOOK_I.miss && !LOOK_I.prot_ok)
      begin
        kind     = EK_PROT; // RQ1
        nxt_code = CODE_PROT_RD; // RQ2
      end
    end
  end

  always_comb
  begin
    nxt_vector = vector_base_ff;
    unique case (kind)
      EK_RESET: nxt_vector = VEC_RESET; // RQ5
      EK_MISS:  nxt_vector = vector_base_ff + OFS_MISS; // RQ9
      EK_PROT:  nxt_vector = vector_base_ff + OFS_GENERAL; // RQ12
      EK_IPW:   nxt_vector = vector_base_ff + OFS_GENERAL; // RQ12
      EK_NONE:  nxt_vector = vector_base_ff;
    endcase
  end

  // block bit masks further non-reset requests
  assign blocked  = status_word_ff[BL_POS];
  assign take_gen = (kind != EK_NONE) & (kind != EK_RESET) & ~blocked;
  assign take     = take_gen | (kind == EK_RESET);

  // ==========================================================
  // event code, fault address and vector
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      exception_event_code_ff <= CODE_NONE;
    else if (take)
      exception_event_code_ff <= nxt_code; // RQ2 RQ5 RQ8 RQ11 RQ14
    else if (wr_en && PADDR_I == OFS_CODE)
      exception_event_code_ff <= PWDATA_I[11:0];
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      fault_address_reg_ff <= RST_ZERO;
    else if (take)
      fault_address_reg_ff <= ACC_I.vaddr; // RQ5 RQ15 RQ24
    else if (wr_en && PADDR_I == OFS_FAR)
      fault_address_reg_ff <= PWDATA_I;
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      exc_ff       <= 1'b0;
      exc_reset_ff <= 1'b0;
      vector_ff    <= VEC_RESET;
    end
    else
    begin
      exc_ff       <= take;
      exc_reset_ff <= take & (kind == EK_RESET); // RQ6
      if (take)
        vector_ff <= nxt_vector; // RQ9 RQ12
    end
  end

  assign EXC_O       = exc_ff;
  assign EXC_RESET_O = exc_reset_ff;
  assign VECTOR_O    = vector_ff;

  // ==========================================================
  // page entry registers
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      page_entry_high_ff <= RST_ZERO;
    else if (take_gen)
      page_entry_high_ff[31:PAGE_LSB] <= ACC_I.vaddr[31:PAGE_LSB]; // RQ15
    else if (wr_en && PADDR_I == OFS_PEH)
      page_entry_high_ff <= PWDATA_I;
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      page_entry_low_ff    <= RST_ZERO;
      page_entry_assist_ff <= RST_ZERO;
    end
    else if (wr_en && PADDR_I == OFS_PEL)
      page_entry_low_ff <= PWDATA_I; // RQ19
    else if (wr_en && PADDR_I == OFS_PEA)
      page_entry_assist_ff <= PWDATA_I; // RQ19
  end

  // ==========================================================
  // saved context
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      saved_program_counter_ff <= RST_ZERO;
      saved_status_ff          <= RST_ZERO;
      saved_general_ff         <= RST_ZERO;
    end
    else if (take_gen)
    begin
      saved_program_counter_ff <= ACC_I.delay_slot ?
                                  ACC_I.branch_pc : ACC_I.pc; // RQ16
      saved_status_ff          <= status_word_ff; // RQ17
      saved_general_ff         <= STACK_I; // RQ17
    end
    else if (wr_en)
    begin
      if (PADDR_I == OFS_SPC)
        saved_program_counter_ff <= PWDATA_I;
      if (PADDR_I == OFS_SST)
        saved_status_ff <= PWDATA_I;
      if (PADDR_I == OFS_SGR)
        saved_general_ff <= PWDATA_I;
    end
  end

  // ==========================================================
  // status word and vector base
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      status_word_ff <= RST_STW;
    else if (take && kind == EK_RESET)
      status_word_ff <= RST_STW; // RQ6
    else if (take_gen)
    begin
      status_word_ff[MD_POS] <= 1'b1; // RQ18
      status_word_ff[BL_POS] <= 1'b1; // RQ18
      status_word_ff[RB_POS] <= 1'b1; // RQ18
    end
    else if (wr_en && PADDR_I == OFS_STW)
      status_word_ff <= PWDATA_I;
  end

  assign STATUS_O = status_word_ff;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      vector_base_ff <= RST_ZERO;
    else if (wr_en && PADDR_I == OFS_VBR)
      vector_base_ff <= PWDATA_I;
  end

  // ==========================================================
  // replacement counter and buffer load
  logic [CNT_W-1:0] cnt_wrap;
  logic [CNT_W-1:0] cnt_inc;

  assign cnt_inc  = replace_counter_ff + CNT_W'(1);
  assign cnt_wrap = (replace_bound_ff != '0 &&
                     replace_counter_ff >= replace_bound_ff) ||
                    (32'(replace_counter_ff) >= ENTRIES - 1) ?
                    '0 : cnt_inc;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      replace_counter_ff <= '0;
      replace_bound_ff   <= '0;
    end
    else if (LOAD_I)
      replace_counter_ff <= cnt_wrap; // RQ20
    else if (wr_en && PADDR_I == OFS_XCTL)
    begin
      replace_counter_ff <= PWDATA_I[CNT_LSB +: CNT_W]; // RQ20
      replace_bound_ff   <= PWDATA_I[BND_LSB +: CNT_W];
    end
  end

  // only the unified buffer is written; instruction buffer untouched
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      ub_we_ff  <= 1'b0;
      ub_idx_ff <= '0;
      ub_hi_ff  <= RST_ZERO;
      ub_lo_ff  <= RST_ZERO;
      ub_as_ff  <= RST_ZERO;
    end
    else
    begin
      ub_we_ff <= LOAD_I; // RQ23
      if (LOAD_I)
      begin
        ub_idx_ff <= replace_counter_ff; // RQ23
        ub_hi_ff  <= page_entry_high_ff; // RQ23
        ub_lo_ff  <= page_entry_low_ff; // RQ23
        ub_as_ff  <= page_entry_assist_ff; // RQ23
      end
    end
  end

  assign UB_WE_O  = ub_we_ff;
  assign UB_IDX_O = ub_idx_ff;
  assign UB_HI_O  = ub_hi_ff;
  assign UB_LO_O  = ub_lo_ff;
  assign UB_AS_O  = ub_as_ff;

endmodule
`default_nettype wire

// >>> sim/mte_unit_props.sv
`default_nettype none
module mte_unit_props
  import mte_pkg::*;
(
  input wire logic             CLK_I,
  input wire logic             RST_I,
  input wire logic             ACC_VALID_I,
  input wire mte_acc_t         ACC_I,
  input wire mte_look_t        LOOK_I,
  input wire logic             REFILL_MULTI_I,
  input wire logic             LOAD_I,
  input wire logic             EXC_O,
  input wire logic             EXC_RESET_O,
  input wire logic [31:0]      VECTOR_O,
  input wire logic [31:0]      STATUS_O,
  input wire logic             UB_WE_O,
  input wire logic [CNT_W-1:0] UB_IDX_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ==========================================================
  // access decode
  logic mh;
  logic blk;
  logic hit;
  logic quiet;
  assign mh = LOOK_I.multi | (~ACC_I.is_data & REFILL_MULTI_I);
  assign blk = STATUS_O[BL_POS];
  assign hit = ~mh & ~LOOK_I.miss & ~blk;
  assign quiet = ~ACC_VALID_I | (~mh & (ACC_I.is_data ?
    (hit & LOOK_I.prot_ok & (~ACC_I.is_write | LOOK_I.written)) :
    (LOOK_I.miss | LOOK_I.prot_ok)));
  // ==========================================================
  // assertions
  a_multi_reset: assert property (ACC_VALID_I && mh |=>
    EXC_O && EXC_RESET_O && VECTOR_O == VEC_RESET)
    else $error("multiple hit without reset exception");
  a_reset_status: assert property (EXC_RESET_O |->
    STATUS_O == RST_STW) else $error("status not reloaded");
  a_data_miss: assert property (ACC_VALID_I && ACC_I.is_data &&
    !mh && LOOK_I.miss && !blk |=> EXC_O ##0 !EXC_RESET_O)
    else $error("data miss not raised");
  a_fetch_prot: assert property (ACC_VALID_I && !ACC_I.is_data &&
    hit && !LOOK_I.prot_ok |=> EXC_O && !EXC_RESET_O)
    else $error("fetch protection not raised");
  a_init_write: assert property (ACC_VALID_I && ACC_I.is_data &&
    ACC_I.is_write && hit && LOOK_I.prot_ok && !LOOK_I.written
    |=> EXC_O) else $error("initial write not raised");
  a_quiet_access: assert property (quiet |=> !EXC_O)
    else $error("exception without cause");
  a_mask_set: assert property (EXC_O && !EXC_RESET_O |->
    STATUS_O[MD_POS] && STATUS_O[RB_POS] && blk)
    else $error("status bits not set");
  a_load_write: assert property (LOAD_I |=> UB_WE_O)
    else $error("buffer load not issued");
  a_index_held: assert property (!LOAD_I |=>
    !UB_WE_O && $stable(UB_IDX_O)) else $error("index moved");
  c_multi: cover property (ACC_VALID_I && mh);
  c_fault: cover property (EXC_O && !EXC_RESET_O);
  c_load: cover property (UB_WE_O);
endmodule
bind mte_unit mte_unit_props i_mte_unit_props (
  .CLK_I, .RST_I, .ACC_VALID_I, .ACC_I, .LOOK_I, .REFILL_MULTI_I,
  .LOAD_I, .EXC_O, .EXC_RESET_O, .VECTOR_O, .STATUS_O, .UB_WE_O,
  .UB_IDX_O
);
`default_nettype wire

// >>> sim/mte_pipe.sv
`default_nettype none
module mte_pipe
  import mte_pkg::*;
(
  input  wire logic   clk_i,
  output logic        acc_valid_o,
  output mte_acc_t    acc_o,
  output mte_look_t   look_o,
  output logic        refill_multi_o,
  output logic [31:0] stack_o,
  output logic        load_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    acc_valid_o = 1'b0;
    acc_o = '0;
    look_o = '0;
    refill_multi_o = 1'b0;
    stack_o = '0;
    load_o = 1'b0;
  end
  // ==========================================================
  // one access a cycle, idle lines inverted
  task automatic access(input mte_acc_t a, input mte_look_t l,
                        input logic rm);
    @(posedge clk_i);
    acc_valid_o <= 1'b1;
    acc_o <= a;
    look_o <= l;
    refill_multi_o <= rm;
    stack_o <= ~a.vaddr;
    @(posedge clk_i);
    acc_valid_o <= 1'b0;
    acc_o <= ~a;
    look_o <= ~l;
    refill_multi_o <= ~rm;
  endtask
  // ==========================================================
  // buffer load pulse, idle cycle follows
  task automatic load();
    @(posedge clk_i);
    load_o <= 1'b1;
    @(posedge clk_i);
    load_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/mte_unit_tb.sv
`default_nettype none
module mte_unit_tb
  import mte_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] VB = 32'h8000_0000;
  localparam logic [31:0] OPEN = 32'h0000_00f0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, vec, stat, hi, lo, as_o;
  logic pready, pslverr, exc, exc_rst, we, av, rm, ld;
  logic [CNT_W-1:0] idx;
  logic [31:0] stack;
  mte_acc_t acc;
  mte_look_t look;
  int err_total = 0;
  int checks_done = 0;
  always #50 clk = ~clk;
  mte_pipe i_mte_pipe (.clk_i(clk), .acc_valid_o(av), .acc_o(acc),
    .look_o(look), .refill_multi_o(rm), .stack_o(stack), .load_o(ld));
  mte_unit i_mte_unit (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .ACC_VALID_I(av), .ACC_I(acc),
    .LOOK_I(look), .REFILL_MULTI_I(rm), .STACK_I(stack),
    .LOAD_I(ld), .EXC_O(exc), .EXC_RESET_O(exc_rst),
    .VECTOR_O(vec), .STATUS_O(stat), .UB_WE_O(we), .UB_IDX_O(idx),
    .UB_HI_O(hi), .UB_LO_O(lo), .UB_AS_O(as_o));
  // ==========================================================
  // shared tasks
  task automatic chk(input string n, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(n, r, exp);
  endtask
  function automatic mte_acc_t mk(input logic [2:0] f,
                                  input logic [11:0] t);
    mk = {f, 16'h5a3c, 4'h1, t, 16'h0c00, 4'h0, t, 16'h0d00, 4'h0, t};
  endfunction
  task automatic go(input logic [2:0] f, input logic [3:0] l,
                    input logic r, input logic [11:0] t);
    i_mte_pipe.access(mk(f, t), l, r);
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rdc("stw", OFS_STW, RST_STW);
    rdc("code", OFS_CODE, 32'h0000_0000);
    chk("vec", vec, VEC_RESET);
    wr(8'h40, 32'hffff_ffff);
    apb(1'b0, 8'h40, 32'h0000_0000, r, e);
    chk("slverr", {31'h0, e}, 32'h0000_0001);
    chk("unmapped", r, 32'h0000_0000);
    wr(OFS_VBR, VB);
    rdc("vbr", OFS_VBR, VB);
  endtask
  task automatic t_fault(input logic [2:0] f, input logic [3:0] l,
    input logic [11:0] t, input logic [31:0] ofs);
    logic [31:0] r;
    logic e;
    mte_acc_t a;
    a = mk(f, t);
    wr(OFS_STW, OPEN);
    go(f, l, 1'b0, t);
    chk("exc", {30'h0, exc, exc_rst}, 32'h0000_0002);
    chk("vec", vec, VB + ofs);
    rdc("code", OFS_CODE, {20'h0, t});
    rdc("far", OFS_FAR, a.vaddr);
    apb(1'b0, OFS_PEH, 32'h0000_0000, r, e);
    chk("peh", r & 32'hffff_fc00, a.vaddr & 32'hffff_fc00);
    rdc("spc", OFS_SPC, f[0] ? a.branch_pc : a.pc);
    rdc("sst", OFS_SST, OPEN);
    rdc("sgr", OFS_SGR, ~a.vaddr);
    rdc("stw", OFS_STW, 32'h7000_00f0);
  endtask
  task automatic t_quiet();
    wr(OFS_STW, OPEN);
    go(3'b100, 4'b0011, 1'b0, 12'h001);
    chk("hit", {31'h0, exc}, 32'h0000_0000);
    go(3'b000, 4'b0110, 1'b0, 12'h002);
    chk("imiss", {31'h0, exc}, 32'h0000_0000);
    wr(OFS_STW, RST_STW);
    go(3'b100, 4'b0100, 1'b0, 12'h003);
    chk("blocked", {31'h0, exc}, 32'h0000_0000);
    rdc("code", OFS_CODE, {20'h0, CODE_PROT_RD});
  endtask
  task automatic t_multi(input logic [2:0] f, input logic [3:0] l,
                         input logic r);
    go(f, l, r, 12'h3f0);
    chk("mexc", {30'h0, exc, exc_rst}, 32'h0000_0003);
    chk("mvec", vec, VEC_RESET);
    rdc("mcode", OFS_CODE, {20'h0, CODE_MULTI});
    rdc("mfar", OFS_FAR, mk(f, 12'h3f0).vaddr);
    rdc("mstw", OFS_STW, RST_STW);
    rdc("mspc", OFS_SPC, mk(3'b000, CODE_PROT_RD).pc);
    wr(OFS_STW, OPEN);
  endtask
  task automatic t_load();
    logic [31:0] r;
    logic e;
    wr(OFS_PEH, 32'h1111_2400);
    wr(OFS_PEL, 32'h2222_0045);
    wr(OFS_PEA, 32'h0000_000f);
    wr(OFS_XCTL, 32'h0000_0403);
    i_mte_pipe.load();
    #1;
    chk("we", {we, 25'h0, idx}, {1'b1, 25'h0, 6'h3});
    chk("hi", hi, 32'h1111_2400);
    chk("lo", lo, 32'h2222_0045);
    chk("as", as_o, 32'h0000_000f);
    i_mte_pipe.load();
    #1;
    chk("idx", {26'h0, idx}, 32'h0000_0004);
    apb(1'b0, OFS_XCTL, 32'h0000_0000, r, e);
    chk("ctr", r & 32'h0000_3f3f, 32'h0000_0400);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fault(3'b100, 4'b0100, CODE_MISS_RD, OFS_MISS);
    t_fault(3'b111, 4'b0110, CODE_MISS_WR, OFS_MISS);
    t_fault(3'b100, 4'b0001, CODE_PROT_RD, OFS_GENERAL);
    t_fault(3'b110, 4'b0000, CODE_PROT_WR, OFS_GENERAL);
    t_fault(3'b110, 4'b0010, CODE_IPW, OFS_GENERAL);
    t_fault(3'b000, 4'b0000, CODE_PROT_RD, OFS_GENERAL);
    t_quiet();
    t_multi(3'b100, 4'b1100, 1'b0);
    t_multi(3'b000, 4'b0100, 1'b1);
    t_multi(3'b000, 4'b1010, 1'b0);
    t_load();
    final_report();
  end
  initial
  begin
    #200_000;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
